/* byte_merge.sv */
/*
  Byte-lane merge of a bus write into a 16-bit register value.
  Assumes lane enables already reflect byte or word access.
*/
`timescale 1ns/1ps
module byte_merge
  import sys_regs_pkg::*;
(
  // Inputs
  input wire logic [15:0] oldValue,
  input wire logic [15:0] writeData,
  input wire logic [1:0] laneEnable,
  input wire logic [15:0] writeMask,
  // Result
  output logic [15:0] merged
);
  logic [15:0] laneMask;
  // Low lane covers bits 7:0, high lane bits 15:8
  assign laneMask = {{8{laneEnable[1]}}, {8{laneEnable[0]}}} & writeMask;
  assign merged = (oldValue & ~laneMask) | (writeData & laneMask);
endmodule

/* pin_edge_detect.sv */
/*
  Edge detector for the reset/NMI pin in NMI role.
  Assumes the pin level is already synchronous to clock.
*/
`timescale 1ns/1ps
module pin_edge_detect (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Pin and control
  input wire logic pinLevel,
  input wire logic fallingSel,
  // Event
  output logic edgeSeen
);
  typedef struct packed {
    logic last;
  } edge_state_t;
  edge_state_t st, next_st;
  // Track previous level
  always_comb begin
    next_st.last = pinLevel;
  end
  always_ff @(posedge clock or posedge rst) begin
    // Pin idles high under the default pull-up; a zero here would invent a rising edge
    if (rst) begin
      st <= '{last: 1'b1};
    end else begin
      st <= next_st;
    end
  end
  // Edge choice only picks which level change counts; toggling it alone raises no event
  assign edgeSeen = fallingSel ? (st.last & ~pinLevel) : (~st.last & pinLevel);
endmodule

/* sys_reset_pin_control_regs.sv */
/*
  System-control register bank: reset/NMI pin control, watchdog flag handling,
  system control, mailbox registers and the three vector generators.
  Assumes a single-cycle 16-bit memory bus with byte lanes and synchronous inputs.
*/
`timescale 1ns/1ps
module sys_reset_pin_control_regs
  import sys_regs_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Memory bus
  input wire logic [15:0] busAddr,
  input wire logic busWrite,
  input wire logic busRead,
  input wire logic busByte,
  input wire logic [15:0] busWriteData,
  output logic [15:0] busReadData,
  // Watchdog
  input wire logic watchdogIntervalMode,
  input wire logic watchdogEvent,
  input wire logic watchdogServiced,
  input wire logic watchdogResetCause,
  output logic watchdogIrqFlag,
  // Mailbox link side
  input wire logic mailboxInWrite0,
  input wire logic mailboxInWrite1,
  input wire logic [15:0] mailboxInData,
  input wire logic mailboxOutRead0,
  input wire logic mailboxOutRead1,
  output logic mailboxIrqPending,
  // Reset/NMI pin
  input wire logic pinLevel,
  output logic pinFilterActive,
  output logic pinResistorEnable,
  output logic pinPullDirection,
  output logic nmiEdgeSelect,
  output logic pinFunctionSelect,
  output logic pinResetRequest,
  output logic nmiEvent
);
  typedef struct packed {
    logic [15:0] pinCtrl;
    logic [15:0] sysCtrl;
    logic [15:0] mbCtrl;
    logic [15:0] mbIn0;
    logic [15:0] mbIn1;
    logic [15:0] mbOut0;
    logic [15:0] mbOut1;
    logic wdtFlag;
    logic wdtCaused;
    logic porCause;
    logic [15:0] readData;
  } regs_state_t;
  regs_state_t st, next_st;

  // Shared offset decode, used for both reads and writes
  function automatic logic hit(input logic [15:0] addr, input logic [4:0] off);
    hit = (addr[15:1] == (SYS_BASE[15:1] + {11'h000, off[4:1]}));
  endfunction

  logic [1:0] lanes;
  logic [15:0] mergedPin, mergedSys, mergedMbc, mergedIn0, mergedIn1, mergedOut0, mergedOut1;
  logic edgeSeen;
  logic [15:0] univValue;

  // Byte lane from address bit 0 on byte access
  // lane steering
  assign lanes = busByte ? (busAddr[0] ? 2'b10 : 2'b01) : 2'b11;

  byte_merge mergePinU (.oldValue(st.pinCtrl), .writeData(busWriteData), .laneEnable(lanes),
    .writeMask(PIN_CTRL_MASK), .merged(mergedPin));
  byte_merge mergeSysU (.oldValue(st.sysCtrl), .writeData(busWriteData), .laneEnable(lanes),
    .writeMask(SYS_CONTROL_MASK), .merged(mergedSys));
  byte_merge mergeMbcU (.oldValue(st.mbCtrl), .writeData(busWriteData), .laneEnable(lanes),
    .writeMask(MBCTL_WMASK), .merged(mergedMbc));
  byte_merge mergeIn0U (.oldValue(st.mbIn0), .writeData(busWriteData), .laneEnable(lanes),
    .writeMask(~ZERO16), .merged(mergedIn0));
  byte_merge mergeIn1U (.oldValue(st.mbIn1), .writeData(busWriteData), .laneEnable(lanes),
    .writeMask(~ZERO16), .merged(mergedIn1));
  byte_merge mergeOut0U (.oldValue(st.mbOut0), .writeData(busWriteData), .laneEnable(lanes),
    .writeMask(~ZERO16), .merged(mergedOut0));
  byte_merge mergeOut1U (.oldValue(st.mbOut1), .writeData(busWriteData), .laneEnable(lanes),
    .writeMask(~ZERO16), .merged(mergedOut1));

  // NMI edge detection on the pin
  pin_edge_detect edgeU (
    .clock(clock),
    .rst(rst),
    .pinLevel(pinLevel),
    .fallingSel(st.pinCtrl[BIT_EDGE]),
    .edgeSeen(edgeSeen)
  );

  // User vector: input mailbox has priority over output mailbox
  assign univValue = (st.mbCtrl[BIT_IN0FG] | st.mbCtrl[BIT_IN1FG]) ? VEC_MBIN :
    ((st.mbCtrl[BIT_OUT0FG] & st.mbCtrl[BIT_OUT1FG]) ? VEC_MBOUT : VEC_NONE);

  // Next state: writes, hardware events and read side effects
  always_comb begin
    next_st = st;
    if (busWrite && hit(busAddr, OFF_SYS_CONTROL)) begin
      next_st.sysCtrl = mergedSys;
    end
    if (busWrite && busAddr == PIN_CTRL_ADDR) begin
      next_st.pinCtrl = mergedPin;
    end else if (busWrite && busAddr == (PIN_CTRL_ADDR + 16'h0001) && busByte) begin
      next_st.pinCtrl = mergedPin;
    end
    if (busWrite && hit(busAddr, OFF_MBCTL)) begin
      next_st.mbCtrl = mergedMbc | (st.mbCtrl & ~MBCTL_WMASK);
    end
    if (busWrite && hit(busAddr, OFF_MBIN0)) begin
      next_st.mbIn0 = mergedIn0;
    end
    if (busWrite && hit(busAddr, OFF_MBIN1)) begin
      next_st.mbIn1 = mergedIn1;
    end
    if (busWrite && hit(busAddr, OFF_MBOUT0)) begin
      next_st.mbOut0 = mergedOut0;
      if (lanes[1]) begin
        next_st.mbCtrl[BIT_OUT0FG] = 1'b0;
      end
    end
    if (busWrite && hit(busAddr, OFF_MBOUT1)) begin
      next_st.mbOut1 = mergedOut1;
      if (lanes[1]) begin
        next_st.mbCtrl[BIT_OUT1FG] = 1'b0;
      end
    end
    // vector writes ignored
    // Reads of mailbox inputs auto-clear unless disabled
    if (busRead && hit(busAddr, OFF_MBIN0) && !st.mbCtrl[BIT_IN0_KEEP]) begin
      next_st.mbCtrl[BIT_IN0FG] = 1'b0;
    end
    if (busRead && hit(busAddr, OFF_MBIN1) && !st.mbCtrl[BIT_IN1_KEEP]) begin
      next_st.mbCtrl[BIT_IN1FG] = 1'b0;
    end
    if (busRead && hit(busAddr, OFF_UNIV)) begin
      if (univValue == VEC_MBIN) begin
        next_st.mbCtrl[BIT_IN0FG] = 1'b0;
        next_st.mbCtrl[BIT_IN1FG] = 1'b0;
      end else if (univValue == VEC_MBOUT) begin
        next_st.mbCtrl[BIT_OUT0FG] = 1'b0;
        next_st.mbCtrl[BIT_OUT1FG] = 1'b0;
      end
    end
    // Link side sets win over software clears
    if (mailboxInWrite0) begin
      next_st.mbIn0 = mailboxInData;
      next_st.mbCtrl[BIT_IN0FG] = 1'b1;
    end
    if (mailboxInWrite1) begin
      next_st.mbIn1 = mailboxInData;
      next_st.mbCtrl[BIT_IN1FG] = 1'b1;
    end
    if (mailboxOutRead0) begin
      next_st.mbCtrl[BIT_OUT0FG] = 1'b1;
    end
    if (mailboxOutRead1) begin
      next_st.mbCtrl[BIT_OUT1FG] = 1'b1;
    end
    // Watchdog flag handling
    if (!watchdogIntervalMode) begin
      if (watchdogEvent) begin
        next_st.wdtFlag = 1'b0;
      end
    end else begin
      if (watchdogServiced) begin
        next_st.wdtFlag = 1'b0;
      end
      // Odd byte address only, so the flag bit rides in the high data lane;
      // a word write to the reset vector must not reach the flag
      if (busWrite && busByte && busAddr == (SYS_BASE + {11'h000, OFF_WDT_FLAG})) begin
        next_st.wdtFlag = busWriteData[BIT_WDT_WRITE];
      end
      if (watchdogEvent) begin
        next_st.wdtFlag = 1'b1;
      end
    end
    // A reset vector read clears only the cause that it reports
    if (busRead && hit(busAddr, OFF_RSTIV)) begin
      if (st.wdtCaused) begin
        next_st.wdtCaused = 1'b0;
      end else begin
        next_st.porCause = 1'b0;
      end
    end
    if (watchdogResetCause) begin
      next_st.wdtCaused = 1'b1;
    end
    // Registered read data
    next_st.readData = ZERO16;
    if (busRead) begin
      if (busAddr[15:1] == PIN_CTRL_ADDR[15:1]) begin
        next_st.readData = st.pinCtrl & PIN_CTRL_MASK;
      end else if (hit(busAddr, OFF_SYS_CONTROL)) begin
        next_st.readData = st.sysCtrl;
      end else if (hit(busAddr, OFF_MBCTL)) begin
        next_st.readData = st.mbCtrl;
      end else if (hit(busAddr, OFF_MBIN0)) begin
        next_st.readData = st.mbIn0;
      end else if (hit(busAddr, OFF_MBIN1)) begin
        next_st.readData = st.mbIn1;
      end else if (hit(busAddr, OFF_MBOUT0)) begin
        next_st.readData = st.mbOut0;
      end else if (hit(busAddr, OFF_MBOUT1)) begin
        next_st.readData = st.mbOut1;
      end else if (hit(busAddr, OFF_UNIV)) begin
        next_st.readData = univValue;
      end else if (hit(busAddr, OFF_RSTIV)) begin
        // watchdog cause reported
        // Newest cause first; the power-on cause waits behind it
        next_st.readData = st.wdtCaused ? VEC_WDT_RESET : (st.porCause ? VEC_POR : VEC_NONE);
      end
    end
  end

  // State register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st.pinCtrl <= PIN_CTRL_RST;
      st.sysCtrl <= SYS_CONTROL_RST;
      st.mbCtrl <= MBCTL_RST;
      st.mbIn0 <= ZERO16;
      st.mbIn1 <= ZERO16;
      st.mbOut0 <= ZERO16;
      st.mbOut1 <= ZERO16;
      st.wdtFlag <= 1'b0;
      st.wdtCaused <= 1'b0;
      st.porCause <= 1'b1;
      st.readData <= ZERO16;
    end else begin
      st <= next_st;
    end
  end

  // Outputs
  assign busReadData = st.readData;
  assign watchdogIrqFlag = st.wdtFlag;
  assign mailboxIrqPending = (univValue != VEC_NONE);
  assign pinFilterActive = st.pinCtrl[BIT_FILTER] & ~st.pinCtrl[BIT_NMISEL];
  assign pinResistorEnable = st.pinCtrl[BIT_PULLEN];
  assign pinPullDirection = st.pinCtrl[BIT_PULLUP];
  assign nmiEdgeSelect = st.pinCtrl[BIT_EDGE];
  assign pinFunctionSelect = st.pinCtrl[BIT_NMISEL];
  assign pinResetRequest = ~st.pinCtrl[BIT_NMISEL] & ~pinLevel;
  // edge events only in NMI role
  assign nmiEvent = st.pinCtrl[BIT_NMISEL] & edgeSeen;

  AST_WDT_SELF_CLEAR: assert property (@(posedge clock) disable iff (rst)
    (!watchdogIntervalMode && watchdogEvent) |=> !watchdogIrqFlag)
    else $error("watchdog flag not cleared on timeout");
  AST_WDT_SERVICE_CLEAR: assert property (@(posedge clock) disable iff (rst)
    (watchdogIntervalMode && watchdogServiced && !watchdogEvent && !busWrite) |=> !watchdogIrqFlag)
    else $error("watchdog flag not cleared on service");
  AST_FILTER_ROLE: assert property (@(posedge clock) disable iff (rst)
    pinFunctionSelect |-> !pinFilterActive)
    else $error("filter active in NMI role");
  AST_NO_NMI_RESET_ROLE: assert property (@(posedge clock) disable iff (rst)
    !pinFunctionSelect |-> !nmiEvent)
    else $error("NMI raised in reset role");
  AST_PIN_RESERVED: assert property (@(posedge clock) disable iff (rst)
    (busRead && busAddr == PIN_CTRL_ADDR) |=> (busReadData[15:5] == 11'h000))
    else $error("pin control reserved bits nonzero");
  AST_BYTE_LANE: assert property (@(posedge clock) disable iff (rst)
    (busWrite && busByte && !busAddr[0] && hit(busAddr, OFF_MBOUT0) && !mailboxInWrite0)
    |=> (st.mbOut0[15:8] == $past(st.mbOut0[15:8])))
    else $error("low byte write disturbed high byte");
  // Cause pulse followed at once by a reset vector read
  sequence seqCauseThenRead;
    watchdogResetCause ##1 (busRead && hit(busAddr, OFF_RSTIV));
  endsequence
  AST_RST_CAUSE: assert property (@(posedge clock) disable iff (rst)
    seqCauseThenRead |=> (busReadData == VEC_WDT_RESET))
    else $error("reset cause not reported");
  // power-on cause when no watchdog cause is held
  AST_POR_CAUSE: assert property (@(posedge clock) disable iff (rst)
    (busRead && hit(busAddr, OFF_RSTIV) && !st.wdtCaused && st.porCause) |=> (busReadData == VEC_POR))
    else $error("power-on cause not reported");
  AST_WDT_INTERVAL_SET: assert property (@(posedge clock) disable iff (rst)
    (watchdogIntervalMode && watchdogEvent) |=> watchdogIrqFlag)
    else $error("watchdog flag not set by interval event");
  // word write lands in system control
  AST_SYS_WORD_WRITE: assert property (@(posedge clock) disable iff (rst)
    (busWrite && !busByte && hit(busAddr, OFF_SYS_CONTROL)) |=> (st.sysCtrl == ($past(busWriteData) & SYS_CONTROL_MASK)))
    else $error("system control word write lost");
  // word write to output mailbox 0 clears its ready flag
  AST_OUT0_FLAG_CLEAR: assert property (@(posedge clock) disable iff (rst)
    (busWrite && !busByte && hit(busAddr, OFF_MBOUT0) && !mailboxOutRead0) |=> !st.mbCtrl[BIT_OUT0FG])
    else $error("output mailbox flag kept after word write");
  // high byte of pin control holds nothing writable
  AST_PIN_HIGH_BYTE: assert property (@(posedge clock) disable iff (rst)
    (busWrite && busByte && busAddr == (PIN_CTRL_ADDR + 16'h0001)) |=> (st.pinCtrl == $past(st.pinCtrl)))
    else $error("pin control changed by high byte write");
  // User vector read while an input flag is pending and the link is quiet
  sequence seqUnivInRead;
    busRead && hit(busAddr, OFF_UNIV) && (st.mbCtrl[BIT_IN0FG] || st.mbCtrl[BIT_IN1FG])
      && !mailboxInWrite0 && !mailboxInWrite1;
  endsequence
  // vector read clears the input flags
  AST_UNIV_READ_CLEAR: assert property (@(posedge clock) disable iff (rst)
    seqUnivInRead |=> (!st.mbCtrl[BIT_IN0FG] && !st.mbCtrl[BIT_IN1FG]))
    else $error("user vector read left input flag set");
  AST_SNIV_ZERO: assert property (@(posedge clock) disable iff (rst)
    (busRead && hit(busAddr, OFF_SNIV)) |=> (busReadData == VEC_NONE))
    else $error("system vector not zero");
  AST_VEC_WRITE_IGNORED: assert property (@(posedge clock) disable iff (rst)
    (busWrite && hit(busAddr, OFF_UNIV) && !mailboxInWrite0 && !mailboxInWrite1)
    |=> (st.mbCtrl == $past(st.mbCtrl)))
    else $error("vector write changed state");
endmodule

/* system_control_pkg.sv */
/*
  Package for the system-control register bank: byte offsets, field positions,
  reset values and vector codes shared by the bank and its helper modules.
  Assumes a 16-bit memory bus with byte addressing.
*/
package sys_regs_pkg;
  localparam logic [15:0] SYS_BASE = 16'h0180;
  localparam logic [15:0] PIN_CTRL_ADDR = 16'h0104;
  localparam logic [4:0] OFF_SYS_CONTROL = 5'h00;
  localparam logic [4:0] OFF_MBCTL = 5'h06;
  localparam logic [4:0] OFF_MBIN0 = 5'h08;
  localparam logic [4:0] OFF_MBIN1 = 5'h0A;
  localparam logic [4:0] OFF_MBOUT0 = 5'h0C;
  localparam logic [4:0] OFF_MBOUT1 = 5'h0E;
  localparam logic [4:0] OFF_UNIV = 5'h1A;
  localparam logic [4:0] OFF_SNIV = 5'h1C;
  localparam logic [4:0] OFF_RSTIV = 5'h1E;
  localparam logic [4:0] OFF_WDT_FLAG = 5'h1F;
  localparam logic [15:0] SYS_CONTROL_RST = 16'h0000;
  localparam logic [15:0] MBCTL_RST = 16'h000C;
  localparam logic [15:0] PIN_CTRL_RST = 16'h001C;
  localparam logic [15:0] PIN_CTRL_MASK = 16'h001F;
  localparam logic [15:0] SYS_CONTROL_MASK = 16'h0025;
  localparam logic [15:0] MBCTL_WMASK = 16'h00D3;
  localparam int BIT_FILTER = 4;
  localparam int BIT_PULLEN = 3;
  localparam int BIT_PULLUP = 2;
  localparam int BIT_EDGE = 1;
  localparam int BIT_NMISEL = 0;
  localparam int BIT_OUT1FG = 3;
  localparam int BIT_OUT0FG = 2;
  localparam int BIT_IN1FG = 1;
  localparam int BIT_IN0FG = 0;
  localparam int BIT_IN1_KEEP = 7;
  localparam int BIT_IN0_KEEP = 6;
  localparam int BIT_WDT_WRITE = 8;
  localparam logic [15:0] VEC_NONE = 16'h0000;
  localparam logic [15:0] VEC_MBIN = 16'h0002;
  localparam logic [15:0] VEC_MBOUT = 16'h0004;
  localparam logic [15:0] VEC_WDT_RESET = 16'h0016;
  localparam logic [15:0] VEC_POR = 16'h0002;
  localparam logic [15:0] ZERO16 = 16'h0000;
endpackage

/* test_sys_reset_pin_control_regs.sv */
/*
  Self-checking testbench for the system-control register bank.
  Assumes the bank answers reads just after the request edge and that
  the pin, watchdog and mailbox inputs are synchronous to clock.
*/
`timescale 1ns/1ps
module test_sys_reset_pin_control_regs
  import sys_regs_pkg::*;
;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [15:0] busAddr = 16'h0000;
  logic busWrite = 1'b0;
  logic busRead = 1'b0;
  logic busByte = 1'b0;
  logic [15:0] busWriteData = 16'h0000;
  logic [15:0] busReadData;
  logic watchdogIntervalMode = 1'b1;
  logic watchdogEvent = 1'b0;
  logic watchdogServiced = 1'b0;
  logic watchdogResetCause = 1'b0;
  logic watchdogIrqFlag;
  logic mailboxInWrite0 = 1'b0;
  logic mailboxInWrite1 = 1'b0;
  logic [15:0] mailboxInData = 16'h0000;
  logic mailboxOutRead0 = 1'b0;
  logic mailboxOutRead1 = 1'b0;
  logic mailboxIrqPending;
  logic pinLevel = 1'b1;
  logic pinFilterActive, pinResistorEnable, pinPullDirection;
  logic nmiEdgeSelect, pinFunctionSelect, pinResetRequest, nmiEvent;
  int num_errors = 0;
  int n_compared = 0;
  logic [15:0] rd;

  sys_reset_pin_control_regs sys_reset_pin_control_regs_i (
    .clock(clock), .rst(rst), .busAddr(busAddr), .busWrite(busWrite), .busRead(busRead),
    .busByte(busByte), .busWriteData(busWriteData), .busReadData(busReadData),
    .watchdogIntervalMode(watchdogIntervalMode), .watchdogEvent(watchdogEvent),
    .watchdogServiced(watchdogServiced), .watchdogResetCause(watchdogResetCause),
    .watchdogIrqFlag(watchdogIrqFlag), .mailboxInWrite0(mailboxInWrite0),
    .mailboxInWrite1(mailboxInWrite1), .mailboxInData(mailboxInData),
    .mailboxOutRead0(mailboxOutRead0), .mailboxOutRead1(mailboxOutRead1),
    .mailboxIrqPending(mailboxIrqPending), .pinLevel(pinLevel), .pinFilterActive(pinFilterActive),
    .pinResistorEnable(pinResistorEnable), .pinPullDirection(pinPullDirection),
    .nmiEdgeSelect(nmiEdgeSelect), .pinFunctionSelect(pinFunctionSelect),
    .pinResetRequest(pinResetRequest), .nmiEvent(nmiEvent)
  );

  // Free-running 100 MHz clock
  always #5 clock = ~clock;

  // Step to just after the next rising edge, where all stimulus changes
  task automatic tick();
    @(posedge clock);
    #1;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] expected);
    n_compared++;
    if (seen !== expected) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, expected, seen);
    end
  endtask

  // Strobe held for exactly one taken edge
  task automatic bus_write(input logic [15:0] addr, input logic [15:0] data, input logic isByte);
    tick();
    busAddr = addr;
    busWriteData = data;
    busByte = isByte;
    busWrite = 1'b1;
    tick();
    busWrite = 1'b0;
  endtask

  // Read data is registered, so it is taken just after the request edge
  task automatic bus_read(input logic [15:0] addr, output logic [15:0] data);
    tick();
    busAddr = addr;
    busByte = 1'b0;
    busRead = 1'b1;
    tick();
    busRead = 1'b0;
    data = busReadData;
  endtask

  task automatic expect_read(input string what, input logic [15:0] addr, input logic [15:0] expected);
    bus_read(addr, rd);
    check(what, rd, expected);
  endtask

  // Event pulse stands only until the next rising edge, so look mid-cycle
  task automatic count_nmi(output logic [15:0] seen);
    seen = 16'h0000;
    repeat (4) begin
      @(negedge clock);
      seen = seen | 16'(nmiEvent);
    end
  endtask

  task automatic test_reset_values();
    logic [15:0] addrs [7];
    logic [15:0] vals [7];
    addrs = '{SYS_BASE, SYS_BASE + 16'h0006, SYS_BASE + 16'h0008, SYS_BASE + 16'h000A,
              SYS_BASE + 16'h000C, SYS_BASE + 16'h000E, PIN_CTRL_ADDR};
    vals = '{SYS_CONTROL_RST, MBCTL_RST, ZERO16, ZERO16, ZERO16, ZERO16, PIN_CTRL_RST};
    for (int i = 0; i < 7; i++) begin
      expect_read("reset value", addrs[i], vals[i]);
    end
    expect_read("power-on cause", SYS_BASE + 16'h001E, VEC_POR);
    check("filter active", 16'(pinFilterActive), 16'h0001);
    check("pull enable", 16'(pinResistorEnable), 16'h0001);
    check("pull up", 16'(pinPullDirection), 16'h0001);
    check("edge select", 16'(nmiEdgeSelect), 16'h0000);
    check("pin role", 16'(pinFunctionSelect), 16'h0000);
  endtask

  task automatic test_pin_control();
    // Reserved bits must not stick even when all ones are written
    bus_write(PIN_CTRL_ADDR, 16'hFFFF, 1'b0);
    expect_read("pin control", PIN_CTRL_ADDR, 16'h001F);
    check("filter off in nmi role", 16'(pinFilterActive), 16'h0000);
    check("edge falling", 16'(nmiEdgeSelect), 16'h0001);
    check("nmi role", 16'(pinFunctionSelect), 16'h0001);
    pinLevel = 1'b0;
    count_nmi(rd);
    check("falling nmi", rd, 16'h0001);
    check("no reset in nmi role", 16'(pinResetRequest), 16'h0000);
    // leave NMI role first, then change the edge
    bus_write(PIN_CTRL_ADDR, 16'h0002, 1'b0);
    bus_write(PIN_CTRL_ADDR, 16'h0000, 1'b0);
    check("pull disabled", 16'(pinResistorEnable), 16'h0000);
    check("pull down", 16'(pinPullDirection), 16'h0000);
    check("reset request", 16'(pinResetRequest), 16'h0001);
    bus_write(PIN_CTRL_ADDR, 16'h0001, 1'b0);
    pinLevel = 1'b1;
    count_nmi(rd);
    check("rising nmi", rd, 16'h0001);
    bus_write(PIN_CTRL_ADDR, PIN_CTRL_RST, 1'b0);
    // High half holds only reserved bits
    bus_write(PIN_CTRL_ADDR + 16'h0001, 16'hFF00, 1'b1);
    expect_read("pin control high byte", PIN_CTRL_ADDR, PIN_CTRL_RST);
  endtask

  task automatic test_byte_lanes();
    bus_write(SYS_BASE + 16'h000C, 16'h1234, 1'b0);
    expect_read("out0 flag cleared", SYS_BASE + 16'h0006, 16'h0008);
    bus_write(SYS_BASE + 16'h000D, 16'hAB00, 1'b1);
    expect_read("high byte", SYS_BASE + 16'h000C, 16'hAB34);
    bus_write(SYS_BASE + 16'h000C, 16'h0056, 1'b1);
    expect_read("low byte", SYS_BASE + 16'h000C, 16'hAB56);
    bus_write(SYS_BASE + 16'h000E, 16'h00C3, 1'b1);
    expect_read("out1 low byte", SYS_BASE + 16'h000E, 16'h00C3);
    tick();
    mailboxOutRead0 = 1'b1;
    tick();
    mailboxOutRead0 = 1'b0;
    mailboxOutRead1 = 1'b1;
    tick();
    mailboxOutRead1 = 1'b0;
    expect_read("out flags set", SYS_BASE + 16'h0006, 16'h000C);
  endtask

  task automatic test_mailbox_in();
    tick();
    mailboxInData = 16'hA5C3;
    mailboxInWrite0 = 1'b1;
    tick();
    mailboxInWrite0 = 1'b0;
    check("user interrupt pending", 16'(mailboxIrqPending), 16'h0001);
    expect_read("in0 flag set", SYS_BASE + 16'h0006, 16'h000D);
    expect_read("user vector", SYS_BASE + 16'h001A, VEC_MBIN);
    expect_read("in0 flag cleared", SYS_BASE + 16'h0006, 16'h000C);
    expect_read("in0 data", SYS_BASE + 16'h0008, 16'hA5C3);
    mailboxInData = 16'h5A3C;
    mailboxInWrite1 = 1'b1;
    tick();
    mailboxInWrite1 = 1'b0;
    expect_read("in1 data", SYS_BASE + 16'h000A, 16'h5A3C);
    expect_read("in1 auto cleared", SYS_BASE + 16'h0006, 16'h000C);
  endtask

  task automatic test_watchdog();
    tick();
    watchdogIntervalMode = 1'b1;
    watchdogEvent = 1'b1;
    tick();
    watchdogEvent = 1'b0;
    watchdogServiced = 1'b1;
    tick();
    watchdogServiced = 1'b0;
    check("serviced clears", 16'(watchdogIrqFlag), 16'h0000);
    watchdogEvent = 1'b1;
    tick();
    watchdogEvent = 1'b0;
    // lone flag bit in its byte, so this byte write is its bit-clear
    bus_write(SYS_BASE + 16'h001F, 16'h0000, 1'b1);
    tick();
    check("software clears", 16'(watchdogIrqFlag), 16'h0000);
    watchdogEvent = 1'b1;
    tick();
    watchdogEvent = 1'b0;
    check("interval sets", 16'(watchdogIrqFlag), 16'h0001);
    watchdogIntervalMode = 1'b0;
    watchdogEvent = 1'b1;
    tick();
    watchdogEvent = 1'b0;
    tick();
    check("timeout clears", 16'(watchdogIrqFlag), 16'h0000);
    watchdogResetCause = 1'b1;
    tick();
    watchdogResetCause = 1'b0;
    // Read right behind the cause pulse
    busAddr = SYS_BASE + 16'h001E;
    busByte = 1'b0;
    busRead = 1'b1;
    tick();
    busRead = 1'b0;
    check("reset cause", busReadData, VEC_WDT_RESET);
    expect_read("reset cause read clears", SYS_BASE + 16'h001E, VEC_NONE);
  endtask

  task automatic test_read_only();
    bus_write(SYS_BASE + 16'h001E, 16'hFFFF, 1'b0);
    expect_read("reset vector write", SYS_BASE + 16'h001E, VEC_NONE);
    bus_write(SYS_BASE + 16'h001C, 16'hFFFF, 1'b0);
    expect_read("system vector write", SYS_BASE + 16'h001C, VEC_NONE);
    bus_write(SYS_BASE + 16'h001A, 16'hFFFF, 1'b0);
    bus_write(SYS_BASE + 16'h000C, 16'h0000, 1'b0);
    bus_write(SYS_BASE + 16'h000E, 16'h0000, 1'b0);
    expect_read("user vector write", SYS_BASE + 16'h001A, VEC_NONE);
    check("no user interrupt", 16'(mailboxIrqPending), 16'h0000);
    expect_read("unmapped", SYS_BASE + 16'h0010, ZERO16);
    bus_write(SYS_BASE, 16'hFFFF, 1'b0);
    expect_read("system control", SYS_BASE, SYS_CONTROL_MASK);
  endtask

  task automatic final_report();
    if (num_errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Reset for three cycles, then the scenarios in turn
  initial begin
    repeat (3) @(posedge clock);
    #1;
    rst = 1'b0;
    test_reset_values();
    test_pin_control();
    test_byte_lanes();
    test_mailbox_in();
    test_watchdog();
    test_read_only();
    final_report();
  end

  // Whole run needs about 120 cycles; this cuts a hang short
  initial begin
    #50000;
    num_errors++;
    final_report();
  end
endmodule
